// ==== dbsw_defs.svh ====
`ifndef DBSW_DEFS_SVH
`define DBSW_DEFS_SVH

// ==========================================================
// bus and wait-switch widths
`define DBSW_AW 32
`define DBSW_DW 32
`define DBSW_WSW 3

// ==========================================================
// memory disable decode
`define DBSW_OPT_DISABLE 3'h6

// ==========================================================
// data request type codes
`define DBSW_DQT_IDMEM 2'h0
`define DBSW_DQT_IO 2'h1
`define DBSW_DQT_IMEM 2'h2

// ==========================================================
// instruction request type codes
`define DBSW_IQT_IMEM 1'h0
`define DBSW_IQT_IDMEM 1'h1

// ==========================================================
// serial controller window in the data i/o space
`define DBSW_SER_BASE 32'h0000_8000
`define DBSW_SER_MASK 32'hFFFF_FF00

// ==========================================================
// reset values
`define DBSW_RST_WORD 32'h0000_0000
`define DBSW_RST_WS 3'h0

`endif

// ==== dbsw_pkg.sv ====
package dbsw_pkg;

  // ========================================================
  // request bundles as seen on the processor pins
  typedef struct packed {
    logic req;
    logic rd;
    logic [1:0] typ;
    logic [31:0] addr;
  } dbsw_data_request_t;

  typedef struct packed {
    logic req;
    logic typ;
    logic [31:0] addr;
  } dbsw_instr_request_t;

  // ========================================================
  // access sequencer states, gray along idle-wait-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_DONE = 2'h3
  } dbsw_state_t;

  // ========================================================
  // swap buffer steering
  typedef enum logic [1:0] {
    SW_OFF = 2'h0,
    SW_I2D = 2'h1,
    SW_D2I = 2'h2
  } dbsw_swap_t;

endpackage

// ==== dbsw_wait_gen.sv ====
`timescale 1ns/10ps
`include "dbsw_defs.svh"

module dbsw_wait_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [2:0] ws_i,
  output logic done_o
);

  logic busy_q;
  logic busy_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // ========================================================
  // count down the switch setting, then flag completion
  assign busy_d = start_i ? 1'b1 : (done_o ? 1'b0 : busy_q);
  assign cnt_d = start_i ? ws_i : (busy_q && cnt_q != 3'h0 ? cnt_q - 3'h1 : cnt_q);
  assign done_o = busy_q && (cnt_q == 3'h0);

  // a zero setting still gives one memory cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      cnt_q <= `DBSW_RST_WS;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// ==== dbsw_serial_dec.sv ====
`timescale 1ns/10ps
`include "dbsw_defs.svh"

module dbsw_serial_dec (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input dbsw_pkg::dbsw_data_request_t data_request_i,
  input wire logic ser_rdy_i,
  input wire logic ser_irq_i,
  input wire logic irq_to_trap_i,
  output logic ser_cs_o,
  output logic ser_done_o,
  output logic intr_o,
  output logic trap_o
);

  logic hit;
  logic cs_q;
  logic cs_d;

  // ========================================================
  // registers of the serial controller sit in data i/o space
  assign hit = data_request_i.req && (data_request_i.typ == `DBSW_DQT_IO) &&
               ((data_request_i.addr & `DBSW_SER_MASK) == `DBSW_SER_BASE);
  assign cs_d = hit ? 1'b1 : (ser_rdy_i ? 1'b0 : cs_q);
  assign ser_cs_o = cs_q;
  assign ser_done_o = cs_q && ser_rdy_i;

  // interrupt request goes to one processor input, strap chosen
  assign intr_o = ser_irq_i && !irq_to_trap_i;
  assign trap_o = ser_irq_i && irq_to_trap_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b0;
    end else begin
      cs_q <= cs_d;
    end
  end

  AST_SER_SELECT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hit |=> ser_cs_o) else $error("serial select missed");

endmodule

// ==== dbsw_top.sv ====
`timescale 1ns/10ps
`include "dbsw_defs.svh"

// Functional notes
// - option code six disables memories when selected
// - low alignment pin disables memories when selected and adapter present
// - static select picks disable method
// - independent zero-to-seven wait states per space
// - both buses share one address map
// - swap enable/direction decoded from request signals
// - data read of instruction memory via swap
// - fetch from instruction/data memory via swap
// - ordinary accesses bypass the swap buffer
// - hold mode-control inputs high without adapter
// - hold alignment pin high without adapter, except while the swap drives the data bus
// - adapter-shared lines driven only three-state
// - serial controller mapped in data space, irq routed
module dbsw_top (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input dbsw_pkg::dbsw_data_request_t DATA_REQUEST_I,
  input dbsw_pkg::dbsw_instr_request_t INSTR_REQUEST_I,
  input wire logic [2:0] OPTION_CODE_I,
  input wire logic DISABLE_METHOD_SELECT_I,
  input wire logic ALIGNMENT_PIN_I,
  input wire logic ADAPTER_PRESENT_I,
  input wire logic [2:0] IMEM_WAIT_I,
  input wire logic [2:0] IDMEM_WAIT_I,
  input wire logic [31:0] DBUS_I,
  input wire logic [31:0] IBUS_I,
  input wire logic SER_RDY_I,
  input wire logic SER_IRQ_I,
  input wire logic IRQ_TO_TRAP_I,
  output logic [31:0] DBUS_O,
  output logic DBUS_OE_O,
  output logic [31:0] IBUS_O,
  output logic IBUS_OE_O,
  output logic TRANSCEIVER_OUTPUT_ENABLE_O,
  output logic SWAP_DIR_O,
  output logic [31:0] MEM_ADDR_O,
  output logic IMEM_CS_O,
  output logic IDMEM_CS_O,
  output logic MEM_WE_O,
  output logic MEM_DISABLED_O,
  output logic DRDY_O,
  output logic IRDY_O,
  output logic [1:0] PROCESSOR_MODE_INPUTS_O,
  output logic PROCESSOR_MODE_INPUTS_OE_O,
  output logic ALIGN_HOLD_O,
  output logic ALIGN_HOLD_OE_O,
  output logic SER_CS_O,
  output logic INTR_O,
  output logic TRAP_O
);

  // ========================================================
  // declarations
  dbsw_pkg::dbsw_state_t state_q;
  dbsw_pkg::dbsw_state_t state_d;
  dbsw_pkg::dbsw_swap_t mode_q;
  dbsw_pkg::dbsw_swap_t mode_d;
  dbsw_pkg::dbsw_data_request_t dlat_q;
  dbsw_pkg::dbsw_instr_request_t ilat_q;
  logic d_pend_q;
  logic d_pend_d;
  logic i_pend_q;
  logic i_pend_d;
  logic cur_instr_q;
  logic cur_rd_q;
  logic cur_space_q;
  logic [31:0] cur_addr_q;
  logic [31:0] swap_q;
  logic [31:0] swap_d;
  logic off_q;
  logic align_eff;
  logic opt_off;
  logic pin_off;
  logic mem_off;
  logic d_mem_type;
  logic d_new;
  logic i_new;
  logic idle;
  logic take_d;
  logic take_i;
  logic take;
  logic nxt_instr;
  logic nxt_rd;
  logic nxt_space;
  logic [31:0] nxt_addr;
  logic [1:0] start_w;
  logic [1:0] done_w;
  logic [2:0] ws_w [2];
  logic wait_done;
  logic ser_done;

  // ========================================================
  // memory disable decode; without an adapter the alignment line
  // is held high, so a floating pin cannot drop memory out
  assign align_eff = ADAPTER_PRESENT_I ? ALIGNMENT_PIN_I : 1'b1;
  assign opt_off = (OPTION_CODE_I == `DBSW_OPT_DISABLE);
  assign pin_off = !align_eff;
  assign mem_off = DISABLE_METHOD_SELECT_I ? opt_off : pin_off;

  // ========================================================
  // request capture; a disabled access is left to the adapter
  assign d_mem_type = (DATA_REQUEST_I.typ == `DBSW_DQT_IDMEM) ||
                      (DATA_REQUEST_I.typ == `DBSW_DQT_IMEM);
  assign d_new = DATA_REQUEST_I.req && d_mem_type && !mem_off;
  assign i_new = INSTR_REQUEST_I.req && !mem_off;
  assign idle = (state_q == dbsw_pkg::ST_IDLE);
  assign take_d = idle && d_pend_q;
  assign take_i = idle && !d_pend_q && i_pend_q;
  assign take = take_d || take_i;
  // a new request in the taking cycle is kept: set wins
  assign d_pend_d = d_new ? 1'b1 : (take_d ? 1'b0 : d_pend_q);
  assign i_pend_d = i_new ? 1'b1 : (take_i ? 1'b0 : i_pend_q);

  // ========================================================
  // next access; one address map serves both buses unchanged
  assign nxt_instr = take_i;
  assign nxt_rd = take_i ? 1'b1 : dlat_q.rd;
  assign nxt_space = take_i ? (ilat_q.typ == `DBSW_IQT_IDMEM) :
                     (dlat_q.typ == `DBSW_DQT_IDMEM);
  assign nxt_addr = take_i ? ilat_q.addr : dlat_q.addr;

  // ========================================================
  // swap steering from bus, request type and direction
  always_comb begin
    mode_d = mode_q;
    if (take) begin
      mode_d = dbsw_pkg::SW_OFF;
      if (!nxt_instr && !nxt_space && nxt_rd) begin
        mode_d = dbsw_pkg::SW_I2D;
      end else if (!nxt_instr && !nxt_space) begin
        mode_d = dbsw_pkg::SW_D2I;
      end else if (nxt_instr && nxt_space) begin
        mode_d = dbsw_pkg::SW_D2I;
      end
    end else if (state_q == dbsw_pkg::ST_DONE) begin
      mode_d = dbsw_pkg::SW_OFF;
    end
  end

  // ========================================================
  // access sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dbsw_pkg::ST_IDLE: begin
        if (take) begin
          state_d = dbsw_pkg::ST_WAIT;
        end
      end
      dbsw_pkg::ST_WAIT: begin
        if (wait_done) begin
          state_d = dbsw_pkg::ST_DONE;
        end
      end
      dbsw_pkg::ST_DONE: begin
        state_d = dbsw_pkg::ST_IDLE;
      end
      default: begin
        state_d = dbsw_pkg::ST_IDLE;
      end
    endcase
  end

  // ========================================================
  // one wait-state generator per memory space
  assign ws_w[0] = IMEM_WAIT_I;
  assign ws_w[1] = IDMEM_WAIT_I;
  generate
    for (genvar k = 0; k < 2; k++) begin : g_ws
      assign start_w[k] = take && (nxt_space == 1'(k));
      dbsw_wait_gen u_wait (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .start_i(start_w[k]),
        .ws_i(ws_w[k]),
        .done_o(done_w[k])
      );
    end
  endgenerate
  assign wait_done = cur_space_q ? done_w[1] : done_w[0];

  // ========================================================
  // swap register follows the source bus until the answer cycle,
  // so the word driven out is the one the source bus last presented
  assign swap_d = (state_q == dbsw_pkg::ST_DONE) ? swap_q :
                  ((mode_q == dbsw_pkg::SW_I2D && !idle) ? IBUS_I : DBUS_I);

  // ========================================================
  // state registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= dbsw_pkg::ST_IDLE;
      mode_q <= dbsw_pkg::SW_OFF;
      d_pend_q <= 1'b0;
      i_pend_q <= 1'b0;
      off_q <= 1'b0;
      swap_q <= `DBSW_RST_WORD;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      d_pend_q <= d_pend_d;
      i_pend_q <= i_pend_d;
      off_q <= mem_off;
      swap_q <= swap_d;
    end
  end

  // request latches and the current access
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dlat_q <= '0;
      ilat_q <= '0;
      cur_instr_q <= 1'b0;
      cur_rd_q <= 1'b0;
      cur_space_q <= 1'b0;
      cur_addr_q <= `DBSW_RST_WORD;
    end else begin
      if (d_new) begin
        dlat_q <= DATA_REQUEST_I;
      end
      if (i_new) begin
        ilat_q <= INSTR_REQUEST_I;
      end
      if (take) begin
        cur_instr_q <= nxt_instr;
        cur_rd_q <= nxt_rd;
        cur_space_q <= nxt_space;
        cur_addr_q <= nxt_addr;
      end
    end
  end

  // ========================================================
  // swap buffer drive; nothing crosses outside the transfer cases
  assign DBUS_O = swap_q;
  assign IBUS_O = swap_q;
  assign DBUS_OE_O = (mode_q == dbsw_pkg::SW_I2D) &&
                     (state_q == dbsw_pkg::ST_DONE);
  assign IBUS_OE_O = (mode_q == dbsw_pkg::SW_D2I) &&
                     ((state_q == dbsw_pkg::ST_DONE) ||
                      (state_q == dbsw_pkg::ST_WAIT && !cur_rd_q));
  assign TRANSCEIVER_OUTPUT_ENABLE_O = DBUS_OE_O || IBUS_OE_O;
  assign SWAP_DIR_O = (mode_q == dbsw_pkg::SW_D2I);

  // ========================================================
  // memory side and processor ready
  assign MEM_ADDR_O = cur_addr_q;
  assign IMEM_CS_O = !idle && !cur_space_q;
  assign IDMEM_CS_O = !idle && cur_space_q;
  assign MEM_WE_O = (state_q == dbsw_pkg::ST_DONE) && !cur_rd_q;
  assign MEM_DISABLED_O = off_q;
  assign DRDY_O = ((state_q == dbsw_pkg::ST_DONE) && !cur_instr_q) || ser_done;
  assign IRDY_O = (state_q == dbsw_pkg::ST_DONE) && cur_instr_q;

  // ========================================================
  // lines the adapter may own: three-state only, released on attach
  assign PROCESSOR_MODE_INPUTS_O = 2'h3;
  assign PROCESSOR_MODE_INPUTS_OE_O = !ADAPTER_PRESENT_I;
  assign ALIGN_HOLD_O = 1'b1;
  assign ALIGN_HOLD_OE_O = !ADAPTER_PRESENT_I && !DBUS_OE_O;

  // ========================================================
  // serial controller decode
  dbsw_serial_dec u_ser (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .data_request_i(DATA_REQUEST_I),
    .ser_rdy_i(SER_RDY_I),
    .ser_irq_i(SER_IRQ_I),
    .irq_to_trap_i(IRQ_TO_TRAP_I),
    .ser_cs_o(SER_CS_O),
    .ser_done_o(ser_done),
    .intr_o(INTR_O),
    .trap_o(TRAP_O)
  );

  // ========================================================
  // checks
  logic [3:0] wcnt_q;
  logic [2:0] wsel_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wcnt_q <= 4'h0;
      wsel_q <= 3'h0;
    end else begin
      wcnt_q <= take ? 4'h0 : (state_q == dbsw_pkg::ST_WAIT ? wcnt_q + 4'h1 : wcnt_q);
      wsel_q <= take ? (nxt_space ? IDMEM_WAIT_I : IMEM_WAIT_I) : wsel_q;
    end
  end

  sequence s_idle_req;
    idle && !d_pend_q && !i_pend_q && DATA_REQUEST_I.req && d_mem_type;
  endsequence

  sequence s_answer_i2d;
    (state_q == dbsw_pkg::ST_DONE) && (mode_q == dbsw_pkg::SW_I2D);
  endsequence

  AST_OPT_DISABLE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_idle_req and DISABLE_METHOD_SELECT_I && OPTION_CODE_I == `DBSW_OPT_DISABLE
    |=> !d_pend_q ##1 idle) else $error("option code did not disable");
  AST_PIN_DISABLE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_idle_req and !DISABLE_METHOD_SELECT_I && ADAPTER_PRESENT_I && !ALIGNMENT_PIN_I
    |=> !d_pend_q ##1 idle) else $error("alignment pin did not disable");
  AST_SEL_ENABLE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_idle_req and DISABLE_METHOD_SELECT_I && OPTION_CODE_I != `DBSW_OPT_DISABLE
    |=> d_pend_q ##1 (state_q == dbsw_pkg::ST_WAIT)) else $error("enabled access lost");
  AST_WAIT_COUNT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(state_q == dbsw_pkg::ST_DONE) |-> wcnt_q == {1'b0, wsel_q} + 4'h1)
    else $error("wait state count wrong");
  AST_SAME_ADDR: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    take |=> MEM_ADDR_O == $past(nxt_addr) && IMEM_CS_O != IDMEM_CS_O)
    else $error("address changed between buses");
  AST_I2D: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_answer_i2d |-> DBUS_OE_O && !IBUS_OE_O && DBUS_O == $past(IBUS_I) && DRDY_O)
    else $error("instruction word not steered to data bus");
  AST_D2I: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    take_i && nxt_space |=> (state_q == dbsw_pkg::ST_WAIT && SWAP_DIR_O)
    ##[0:8] (IBUS_OE_O && IRDY_O)) else $error("fetch not steered to instr bus");
  // direct cases: data to instr/data memory, fetch from instr memory
  AST_DIRECT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    take && (nxt_instr ^ nxt_space) |=> !TRANSCEIVER_OUTPUT_ENABLE_O [*2])
    else $error("direct access used swap");
  AST_MODE_HIGH: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !ADAPTER_PRESENT_I |-> PROCESSOR_MODE_INPUTS_OE_O && PROCESSOR_MODE_INPUTS_O == 2'h3)
    else $error("mode inputs not held high");
  AST_IDLE_OFF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    idle || mode_q == dbsw_pkg::SW_OFF |-> !TRANSCEIVER_OUTPUT_ENABLE_O)
    else $error("swap enabled outside a transfer");
  AST_RELEASE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ADAPTER_PRESENT_I |-> !PROCESSOR_MODE_INPUTS_OE_O && !ALIGN_HOLD_OE_O)
    else $error("adapter line still driven");

endmodule

// ==== dbsw_mem_model.sv ====
`timescale 1ns/10ps

// ==========================================================
// memory pair behind the block, one word per address in each space
module dbsw_mem_model (
  input wire logic clk_i,
  input wire logic imem_cs_i,
  input wire logic idmem_cs_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] dbus_i,
  output logic [31:0] ibus_o,
  output logic [31:0] dbus_o
);
  logic [31:0] mem_q [256];
  logic [31:0] last_i_q;
  logic [31:0] last_d_q;

  // unwritten words read back a pattern tied to the address
  initial begin
    for (int k = 0; k < 256; k++) begin
      mem_q[k] = {22'h0, k[7:0], 2'h0} ^ 32'hA5A5_0000;
    end
    last_i_q = 32'h0;
    last_d_q = 32'h0;
  end

  // released buses show the inverse of the previous cycle's word, so they toggle every cycle
  assign ibus_o = imem_cs_i ? (addr_i ^ 32'h3C3C_0000) : ~last_i_q;
  assign dbus_o = idmem_cs_i ? mem_q[addr_i[9:2]] : ~last_d_q;

  // writes land in the strobe cycle with the word seen on the data pins
  always @(posedge clk_i) begin
    if (we_i && idmem_cs_i) begin
      mem_q[addr_i[9:2]] <= dbus_i;
    end
    last_i_q <= ibus_o;
    last_d_q <= dbus_o;
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps

// ==========================================================
// bench for the dual-bus swap block
module tb_top;
  logic clk, rst_n, sel, align, adapter, proc_d_en, ser_rdy, ser_irq, to_trap;
  logic [2:0] option_code, iw, dw;
  logic [31:0] proc_d, dbus_o, ibus_o, mem_addr, mem_d, mem_i, dbus_pin, ibus_pin;
  logic dbus_oe, ibus_oe, xcv_en, swap_dir, imem_cs, idmem_cs, mem_we, mem_dis;
  logic drdy, irdy, mode_oe, align_hold, align_oe, ser_cs, intr, trap;
  logic [1:0] mode;
  logic im_seen, idm_seen, te_seen;
  dbsw_pkg::dbsw_data_request_t dq;
  dbsw_pkg::dbsw_instr_request_t iq;
  int mismatches, total_checks, cyc;

  // pin levels: processor first, then the block, then memory
  assign dbus_pin = proc_d_en ? proc_d : (dbus_oe ? dbus_o : mem_d);
  assign ibus_pin = ibus_oe ? ibus_o : mem_i;

  dbsw_top uut (.CLK_I(clk), .RST_N_I(rst_n), .DATA_REQUEST_I(dq), .INSTR_REQUEST_I(iq),
    .OPTION_CODE_I(option_code), .DISABLE_METHOD_SELECT_I(sel), .ALIGNMENT_PIN_I(align),
    .ADAPTER_PRESENT_I(adapter), .IMEM_WAIT_I(iw), .IDMEM_WAIT_I(dw), .DBUS_I(dbus_pin),
    .IBUS_I(ibus_pin), .SER_RDY_I(ser_rdy), .SER_IRQ_I(ser_irq), .IRQ_TO_TRAP_I(to_trap),
    .DBUS_O(dbus_o), .DBUS_OE_O(dbus_oe), .IBUS_O(ibus_o), .IBUS_OE_O(ibus_oe),
    .TRANSCEIVER_OUTPUT_ENABLE_O(xcv_en), .SWAP_DIR_O(swap_dir), .MEM_ADDR_O(mem_addr),
    .IMEM_CS_O(imem_cs), .IDMEM_CS_O(idmem_cs), .MEM_WE_O(mem_we), .MEM_DISABLED_O(mem_dis),
    .DRDY_O(drdy), .IRDY_O(irdy), .PROCESSOR_MODE_INPUTS_O(mode),
    .PROCESSOR_MODE_INPUTS_OE_O(mode_oe), .ALIGN_HOLD_O(align_hold),
    .ALIGN_HOLD_OE_O(align_oe), .SER_CS_O(ser_cs), .INTR_O(intr), .TRAP_O(trap));

  dbsw_mem_model mem (.clk_i(clk), .imem_cs_i(imem_cs), .idmem_cs_i(idmem_cs),
    .we_i(mem_we), .addr_i(mem_addr), .dbus_i(dbus_pin), .ibus_o(mem_i), .dbus_o(mem_d));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // compare and closing tasks
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // request drivers, one idle cycle before each pulse keeps the order safe
  task automatic launch(input bit data, input logic [1:0] dt, input logic it,
                        input logic rd, input logic [31:0] a);
    @(negedge clk);
    if (data) begin
      dq = '{req: 1'b1, rd: rd, typ: dt, addr: a};
    end else begin
      iq = '{req: 1'b1, typ: it, addr: a};
    end
  endtask

  // cyc counts edges after the latching edge until ready shows
  task automatic access(input bit data, input logic [1:0] dt, input logic it,
                        input logic rd, input logic [31:0] a);
    cyc = -1;
    im_seen = 1'b0;
    idm_seen = 1'b0;
    te_seen = 1'b0;
    launch(data, dt, it, rd, a);
    for (int i = 0; i < 40 && cyc < 0; i++) begin
      @(negedge clk);
      dq.req = 1'b0;
      iq.req = 1'b0;
      im_seen |= imem_cs;
      idm_seen |= idmem_cs;
      te_seen |= xcv_en;
      if (data ? (drdy === 1'b1) : (irdy === 1'b1)) cyc = i;
    end
    if (cyc < 0) begin
      mismatches++;
      summarize();
    end
  endtask

  // a refused request: nothing may answer within eight cycles
  task automatic refused(input logic [31:0] a);
    launch(1'b1, 2'h0, 1'b0, 1'b1, a);
    te_seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      dq.req = 1'b0;
      te_seen |= drdy | idmem_cs | imem_cs;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_swap();
    for (int n = 0; n < 8; n += 7) begin
      iw = n[2:0];
      dw = 3'h3;
      access(1'b1, 2'h2, 1'b0, 1'b1, 32'h0000_0120);
      chk_w(cyc, 2 + n);
      chk_b(im_seen, 1'b1);
      chk_b(dbus_oe, 1'b1);
      chk_w(dbus_o, 32'h0000_0120 ^ 32'h3C3C_0000);
      chk_b(xcv_en, 1'b1);
      chk_b(swap_dir, 1'b0);
      @(negedge clk);
      chk_b(xcv_en, 1'b0);
    end
    $display("test swap read done");
  endtask

  // write over the data bus, then fetch the same address
  task automatic t_fetch();
    iw = 3'h0;
    dw = 3'h5;
    proc_d = 32'h5A0F_C3E1;
    proc_d_en = 1'b1;
    access(1'b1, 2'h0, 1'b0, 1'b0, 32'h0000_0044);
    // write data stays on the pins through the ready edge
    @(negedge clk);
    proc_d_en = 1'b0;
    chk_b(te_seen, 1'b0);
    access(1'b0, 2'h0, 1'b1, 1'b0, 32'h0000_0044);
    chk_w(cyc, 7);
    chk_w(ibus_o, 32'h5A0F_C3E1);
    chk_b(ibus_oe, 1'b1);
    chk_b(swap_dir, 1'b1);
    // download word into instruction memory crosses data to instr
    proc_d = 32'h0C3A_96F0;
    proc_d_en = 1'b1;
    access(1'b1, 2'h2, 1'b0, 1'b0, 32'h0000_0048);
    chk_b(te_seen, 1'b1);
    chk_b(ibus_oe, 1'b1);
    chk_b(swap_dir, 1'b1);
    chk_w(ibus_o, 32'h0C3A_96F0);
    @(negedge clk);
    proc_d_en = 1'b0;
    access(1'b1, 2'h0, 1'b0, 1'b1, 32'h0000_0080);
    chk_b(te_seen, 1'b0);
    chk_b(idm_seen, 1'b1);
    access(1'b0, 2'h0, 1'b0, 1'b0, 32'h0000_0080);
    chk_b(te_seen, 1'b0);
    chk_b(im_seen, 1'b1);
    $display("test fetch done");
  endtask

  task automatic t_disable();
    sel = 1'b1;
    option_code = 3'h6;
    refused(32'h0000_0010);
    chk_b(te_seen, 1'b0);
    chk_b(mem_dis, 1'b1);
    option_code = 3'h5;
    access(1'b1, 2'h0, 1'b0, 1'b1, 32'h0000_0010);
    chk_b(idm_seen, 1'b1);
    sel = 1'b0;
    option_code = 3'h6;
    adapter = 1'b1;
    align = 1'b0;
    refused(32'h0000_0010);
    chk_b(te_seen, 1'b0);
    chk_b(mode_oe, 1'b0);
    chk_b(align_oe, 1'b0);
    align = 1'b1;
    access(1'b1, 2'h0, 1'b0, 1'b1, 32'h0000_0010);
    chk_b(idm_seen, 1'b1);
    adapter = 1'b0;
    align = 1'b0;
    access(1'b1, 2'h0, 1'b0, 1'b1, 32'h0000_0010);
    chk_b(idm_seen, 1'b1);
    chk_b(mode_oe, 1'b1);
    option_code = 3'h0;
    align = 1'b1;
    $display("test disable done");
  endtask

  task automatic t_serial();
    launch(1'b1, 2'h1, 1'b0, 1'b1, 32'h0000_8010);
    @(negedge clk);
    dq.req = 1'b0;
    @(negedge clk);
    chk_b(ser_cs, 1'b1);
    chk_b(drdy, 1'b0);
    ser_rdy = 1'b1;
    #1;
    chk_b(drdy, 1'b1);
    @(negedge clk);
    ser_rdy = 1'b0;
    launch(1'b1, 2'h1, 1'b0, 1'b1, 32'h0000_9010);
    @(negedge clk);
    dq.req = 1'b0;
    @(negedge clk);
    chk_b(ser_cs, 1'b0);
    ser_irq = 1'b1;
    #1;
    chk_b(intr, 1'b1);
    to_trap = 1'b1;
    #1;
    chk_b(trap, 1'b1);
    chk_b(intr, 1'b0);
    ser_irq = 1'b0;
    $display("test serial done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_n = 1'b0;
    dq = '0;
    iq = '0;
    option_code = 3'h0;
    sel = 1'b1;
    align = 1'b1;
    adapter = 1'b0;
    iw = 3'h0;
    dw = 3'h0;
    proc_d = 32'h0;
    proc_d_en = 1'b0;
    ser_rdy = 1'b0;
    ser_irq = 1'b0;
    to_trap = 1'b0;
    repeat (16) @(negedge clk);
    chk_b(xcv_en, 1'b0);
    rst_n = 1'b1;
    @(negedge clk);
    chk_w({30'h0, mode}, 32'h3);
    chk_b(mode_oe, 1'b1);
    chk_b(align_hold, 1'b1);
    chk_b(align_oe, 1'b1);
    $display("test reset done");
    t_swap();
    t_fetch();
    t_disable();
    t_serial();
    summarize();
  end
endmodule
